// [rtl/ccl_pkg.sv]
package ccl_pkg;

  // Bit timing, counted in card clock cycles
  localparam int unsigned ETU_CYC       = 372;  // Cycles per etu
  localparam int unsigned VERIFY_TENTHS = 5;    // Start check point, tenths of etu
  localparam int unsigned MID_CYC       = ETU_CYC * VERIFY_TENTHS / 10;
  localparam logic [8:0]  PH_LAST       = 9'(ETU_CYC - 1);
  localparam logic [8:0]  PH_MID        = 9'(MID_CYC);

  // Frame layout in etu
  localparam logic [8:0]  CHAR_ETU      = 9'h00A;  // Start, 8 data, parity
  localparam logic [8:0]  PAR_BIT       = 9'h009;  // Rank of the parity bit
  localparam logic [8:0]  GUARD_ETU     = 9'h002;  // Minimum guard after a frame
  localparam logic [8:0]  NACK_END      = 9'h00B;  // Error signal ends at 11.5 etu
  localparam logic [7:0]  TC1_SPECIAL   = 8'hFF;   // Extra guard code with own meaning

  // Answer to reset limits
  localparam logic [15:0] ATR_MIN_GAP_ETU = 16'h000C;
  localparam logic [5:0]  ATR_MAX_CHARS   = 6'h21;   // TS plus 32 more
  localparam logic [7:0]  TS_DIRECT       = 8'h3B;
  localparam logic [7:0]  TS_INVERSE      = 8'h3F;
  localparam logic [3:0]  T0_HI_T0        = 4'h6;
  localparam logic [3:0]  T0_HI_T1        = 4'hE;
  localparam logic [7:0]  TB1_VALUE       = 8'h00;
  localparam logic [7:0]  TD1_VALUE       = 8'h81;
  localparam logic [7:0]  TD2_VALUE       = 8'h31;
  localparam logic [7:0]  TA3_MIN         = 8'h10;
  localparam logic [7:0]  TA3_MAX         = 8'hFE;
  localparam logic [3:0]  BWI_MAX         = 4'h4;
  localparam logic [3:0]  CWI_MAX         = 4'h5;
  localparam logic [5:0]  ATR_LEN_T0      = 6'h04;   // Without historical bytes
  localparam logic [5:0]  ATR_LEN_T1      = 6'h09;

  // Register offsets
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h1;
  localparam logic [3:0]  REG_TXDATA = 4'h2;
  localparam logic [3:0]  REG_RXDATA = 4'h3;
  localparam logic [15:0] CTRL_RESET = 16'h0000;

  // Status bit positions: sticky flags, then live busy bit and answer index
  localparam int unsigned FLAG_NUM   = 8;
  localparam int unsigned F_RX_VALID = 0;
  localparam int unsigned F_RX_PERR  = 1;
  localparam int unsigned F_TX_NACK  = 2;
  localparam int unsigned F_GAP_ERR  = 3;
  localparam int unsigned F_TOT_ERR  = 4;
  localparam int unsigned F_CNT_ERR  = 5;
  localparam int unsigned F_CHK_ERR  = 6;
  localparam int unsigned F_TX_OVF   = 7;
  localparam int unsigned S_TX_BUSY  = 8;
  localparam int unsigned S_ATR_IDX  = 16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_TX   = 2'b01,
    ST_RX   = 2'b10,
    ST_NACK = 2'b11
  } ccl_state_t;

  typedef struct packed {
    logic [7:0] guard_extra;  // Extra guard in etu
    logic [4:0] rsvd;
    logic       atr_mode;     // Card is sending its answer to reset
    logic       proto_t1;     // Block protocol, no error signal
    logic       inverse;      // Inverse convention
  } ccl_ctrl_t;

endpackage : ccl_pkg

// [rtl/ccl_link.sv]
// How it works
// - Transmit starts only from idle with the line seen released high.
// - A frame is a low start bit, eight data bits and one parity bit.
// - Parity makes data plus parity ones even; receiver checks it.
// - The line is sampled every clock, far finer than 0.2 etu.
// - Origin at first low sample; start bit rechecked at 0.5 etu.
// - Each received bit is sampled at its half-etu point from origin.
// - Each sent bit lasts exactly one etu from the start edge.
// - Start-to-start spacing is ten etu plus guard; line released during guard.
// - Under T=0 a parity error is signalled by pulling the line low.
// - Byte order is software's; bit order follows the selected convention.
// - Answer-to-reset starts are 12 to 9600 etu apart, checked here.
// - Whole answer-to-reset ends within 19200 etu, checked here.
// - T=0 answer: TS, 6x, 00, then any TC1, then historical bytes.
// - T=1 answer: TS, Ex, 00, TC1, 81, 31, TA3, TB3, history, TCK.
// - TA3 must lie between 10 and FE hex.
// - TB3 high nibble at most 4, low nibble at most 5.
// - TS must be 3B or 3F, matching the selected convention.
// - TC1 sets extra guard etu; FF gives no extra guard.
// - One etu is 372 clock cycles at all times.
// - Inverse: low is one, msb first; direct: high is one, lsb first.
// - At most 32 characters after TS in the answer to reset.
`timescale 1ns/1ps
`default_nettype none

module ccl_link
  import ccl_pkg::*;
#(
  parameter int unsigned ATR_MAX_GAP_ETU = 9600,
  parameter int unsigned ATR_TOTAL_ETU   = 19200
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Card I/O line, open drain
  input  wire logic        io_i,
  output logic             io_o,
  output logic             io_oe_n_o
);

  ccl_state_t           st;
  ccl_state_t           next_st;
  ccl_ctrl_t            ctrl;
  logic       [8:0]     ph;
  logic       [8:0]     next_ph;
  logic       [8:0]     bitn;
  logic       [8:0]     next_bitn;
  logic                 next_rel;
  logic                 io_s1;
  logic                 io_s2;
  logic                 io_prev;
  logic       [7:0]     tx_byte;
  logic       [7:0]     tx_cur;
  logic                 tx_pend;
  logic                 tx_go;
  logic                 nack_seen;
  logic                 rx_done;
  logic       [8:0]     rx_raw;
  logic       [7:0]     rx_byte;
  logic [FLAG_NUM-1:0]  flags;
  logic [FLAG_NUM-1:0]  flag_set;
  logic [FLAG_NUM-1:0]  flag_clr;
  logic       [5:0]     atr_idx;
  logic       [15:0]    gap_cnt;
  logic       [15:0]    tot_cnt;
  logic       [8:0]     etu_ph;
  logic       [3:0]     hist;
  logic       [7:0]     xacc;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // Two-stage pin synchroniser, then edge history
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      io_s1   <= 1'b1;
      io_s2   <= 1'b1;
      io_prev <= 1'b1;
    end
    else
    begin
      io_s1   <= io_i;
      io_s2   <= io_s1;
      io_prev <= io_s2;
    end
  end

  // Register decode
  wire wr_ctrl   = reg_wr_i && (reg_addr_i == REG_CTRL);
  wire wr_status = reg_wr_i && (reg_addr_i == REG_STATUS);
  wire wr_tx     = reg_wr_i && (reg_addr_i == REG_TXDATA);
  wire rd_rx     = reg_rd_i && (reg_addr_i == REG_RXDATA);

  // Line conditions
  wire fall    = io_prev && !io_s2;
  wire ph_wrap = (ph == PH_LAST);
  wire inv     = ctrl.inverse;
  wire t1      = ctrl.proto_t1;

  // Guard length: TC1 extra etu, special code adds none
  wire [8:0] extra     = (ctrl.guard_extra == TC1_SPECIAL) ? 9'h000 : {1'b0, ctrl.guard_extra};
  wire [8:0] guard_end = CHAR_ETU + GUARD_ETU + extra;

  // Bit order and polarity per convention
  logic [7:0] tx_line;
  logic [7:0] rx_dec;
  wire  [8:0] rx_full = {io_s2, rx_raw[8:1]};
  genvar k;
  generate
    for (k = 0; k < 8; k++)
    begin : g_conv
      assign tx_line[k] = inv ? ~tx_cur[7-k] : tx_cur[k];
      assign rx_dec[k]  = inv ? ~rx_full[7-k] : rx_full[k];
    end
  endgenerate

  wire       tx_par   = inv ? ~(^tx_cur) : (^tx_cur);
  wire [9:0] tx_frame = {tx_par, tx_line, 1'b0};
  wire       tx_lvl   = (bitn < CHAR_ETU) ? tx_frame[bitn[3:0]] : 1'b1;
  wire       rx_pbit  = inv ? ~rx_full[8] : rx_full[8];
  wire       par_err  = ^{rx_dec, rx_pbit};
  wire       rx_smp   = (st == ST_RX) && (ph == PH_MID) && (bitn != 9'h000) && (bitn <= PAR_BIT);

  // Answer-to-reset bookkeeping
  wire [5:0] atr_len  = (atr_idx < 6'h02) ? ATR_MAX_CHARS
                      : ((t1 ? ATR_LEN_T1 : ATR_LEN_T0) + {2'b00, hist});
  wire       atr_busy = ctrl.atr_mode && (atr_idx != 6'h00) && (atr_idx < atr_len);
  wire       atr_full = ctrl.atr_mode && (atr_idx == ATR_MAX_CHARS);
  wire       tx_ok    = tx_pend && io_s2 && !atr_full;
  wire       etu_tick = (etu_ph == PH_LAST);

  // Character check against the basic answers
  logic chk_bad;
  always_comb
  begin
    chk_bad = 1'b0;
    if (atr_idx == 6'h00)
      chk_bad = (tx_byte != (inv ? TS_INVERSE : TS_DIRECT));
    else if (atr_idx == 6'h01)
      chk_bad = (tx_byte[7:4] != (t1 ? T0_HI_T1 : T0_HI_T0));
    else if (atr_idx == 6'h02)
      chk_bad = (tx_byte != TB1_VALUE);
    else if (atr_idx >= atr_len)
      chk_bad = 1'b1;
    else if (t1 && (atr_idx == 6'h04))
      chk_bad = (tx_byte != TD1_VALUE);
    else if (t1 && (atr_idx == 6'h05))
      chk_bad = (tx_byte != TD2_VALUE);
    else if (t1 && (atr_idx == 6'h06))
      chk_bad = (tx_byte < TA3_MIN) || (tx_byte > TA3_MAX);
    else if (t1 && (atr_idx == 6'h07))
      chk_bad = (tx_byte[7:4] > BWI_MAX) || (tx_byte[3:0] > CWI_MAX);
    else if (t1 && (atr_idx == atr_len - 6'h01))
      chk_bad = ((xacc ^ tx_byte) != 8'h00);
  end

  // Link sequencer
  always_comb
  begin
    next_st   = st;
    next_ph   = ph_wrap ? 9'h000 : ph + 9'h001;
    next_bitn = ph_wrap ? bitn + 9'h001 : bitn;
    next_rel  = 1'b1;
    tx_go     = 1'b0;
    nack_seen = 1'b0;
    rx_done   = 1'b0;
    case (st)
      ST_IDLE:
      begin
        next_ph   = 9'h000;
        next_bitn = 9'h000;
        if (tx_ok)
        begin
          next_st = ST_TX;
          tx_go   = 1'b1;
        end
        else if (fall)
          next_st = ST_RX;
      end
      ST_TX:
      begin
        next_rel = tx_lvl;
        if (!t1 && (bitn == CHAR_ETU) && ph_wrap && !io_s2)
          nack_seen = 1'b1;
        if (ph_wrap && (next_bitn == guard_end))
          next_st = ST_IDLE;
      end
      ST_RX:
      begin
        if ((bitn == 9'h000) && (ph == PH_MID) && io_s2)
          next_st = ST_IDLE;
        else if ((bitn == PAR_BIT) && (ph == PH_MID))
        begin
          rx_done = 1'b1;
          next_st = (par_err && !t1) ? ST_NACK : ST_IDLE;
        end
      end
      ST_NACK:
      begin
        next_rel = !(((bitn == CHAR_ETU) && (ph >= PH_MID)) ||
                     ((bitn == NACK_END) && (ph < PH_MID)));
        if ((bitn == NACK_END) && (ph == PH_MID))
          next_st = ST_IDLE;
      end
      default:
        next_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      st        <= ST_IDLE;
      ph        <= 9'h000;
      bitn      <= 9'h000;
      io_oe_n_o <= 1'b1;
    end
    else
    begin
      st        <= next_st;
      ph        <= next_ph;
      bitn      <= next_bitn;
      io_oe_n_o <= next_rel;
    end
  end

  // Open drain: only ever pulls low
  assign io_o = 1'b0;

  // Receive shifter and result
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      rx_raw  <= 9'h000;
      rx_byte <= 8'h00;
    end
    else
    begin
      if (rx_smp)
        rx_raw <= rx_full;
      if (rx_done)
        rx_byte <= rx_dec;
    end
  end

  // Control, transmit holding register
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl    <= CTRL_RESET;
      tx_byte <= 8'h00;
      tx_cur  <= 8'h00;
      tx_pend <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= reg_wdata_i[15:0];
      if (wr_tx && !tx_pend && !atr_full)
      begin
        tx_byte <= reg_wdata_i[7:0];
        tx_pend <= 1'b1;
      end
      else if (tx_go)
        tx_pend <= 1'b0;
      // Frame in flight kept apart, so a new write cannot corrupt it
      if (tx_go)
        tx_cur <= tx_byte;
    end
  end

  // Answer-to-reset counters
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i || !ctrl.atr_mode)
    begin
      atr_idx <= 6'h00;
      gap_cnt <= 16'h0000;
      tot_cnt <= 16'h0000;
      etu_ph  <= 9'h000;
      hist    <= 4'h0;
      xacc    <= 8'h00;
    end
    else
    begin
      etu_ph <= etu_tick ? 9'h000 : etu_ph + 9'h001;
      if (tx_go)
      begin
        atr_idx <= atr_idx + 6'h01;
        gap_cnt <= 16'h0000;
        if (atr_idx == 6'h00)
          tot_cnt <= 16'h0000;
        else
          xacc <= xacc ^ tx_byte;
        if (atr_idx == 6'h01)
          hist <= tx_byte[3:0];
      end
      else if (etu_tick && atr_busy)
      begin
        gap_cnt <= gap_cnt + 16'h0001;
        tot_cnt <= tot_cnt + 16'h0001;
      end
    end
  end

  // Sticky flags: hardware set wins over software clear
  assign flag_set[F_RX_VALID] = rx_done;
  assign flag_set[F_RX_PERR]  = rx_done && par_err;
  assign flag_set[F_TX_NACK]  = nack_seen;
  assign flag_set[F_GAP_ERR]  = (tx_go && atr_busy && (gap_cnt < ATR_MIN_GAP_ETU)) ||
                                (atr_busy && (gap_cnt > 16'(ATR_MAX_GAP_ETU)));
  assign flag_set[F_TOT_ERR]  = atr_busy &&
                                (tot_cnt > 16'(ATR_TOTAL_ETU) - ATR_MIN_GAP_ETU);
  assign flag_set[F_CNT_ERR]  = wr_tx && atr_full;
  assign flag_set[F_CHK_ERR]  = tx_go && ctrl.atr_mode && chk_bad;
  assign flag_set[F_TX_OVF]   = wr_tx && tx_pend;

  generate
    for (k = 0; k < FLAG_NUM; k++)
    begin : g_flag
      assign flag_clr[k] = (wr_status && reg_wdata_i[k]) || ((k == F_RX_VALID) && rd_rx);
      always_ff @(posedge core_clk_i)
      begin
        if (sys_rst_i)
          flags[k] <= 1'b0;
        else if (flag_set[k])
          flags[k] <= 1'b1;
        else if (flag_clr[k])
          flags[k] <= 1'b0;
      end
    end
  endgenerate

  // Read mux, data one cycle after the strobe
  wire [31:0] status_word = {10'h000, atr_idx, 7'h00, (tx_pend || (st == ST_TX)), flags};
  wire [31:0] rd_mux = (reg_addr_i == REG_CTRL)   ? {16'h0000, ctrl}
                     : (reg_addr_i == REG_STATUS) ? status_word
                     : (reg_addr_i == REG_RXDATA) ? {24'h000000, rx_byte}
                     : 32'h00000000;

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      reg_rdata_o <= 32'h00000000;
    else
      reg_rdata_o <= reg_rd_i ? rd_mux : 32'h00000000;
  end

  // Checks
  AST_IDLE_RELEASED: assert property ((st == ST_IDLE) && ($past(st) == ST_IDLE) |-> io_oe_n_o)
    else $error("line driven while idle");
  AST_START_LOW: assert property ((st == ST_IDLE) && tx_ok |=> ##1 !io_oe_n_o [*8])
    else $error("start bit not low");
  AST_BIT_TIME: assert property ((st == ST_TX) && ph_wrap |=> (ph == 9'h000) && (bitn == $past(bitn) + 9'h001))
    else $error("bit period not one etu");
  AST_PARITY_LEVEL: assert property ((st == ST_TX) && (bitn == PAR_BIT) && (ph == 9'h005)
    |-> io_oe_n_o == (inv ^ (^tx_cur)))
    else $error("parity level wrong");
  AST_GUARD_RELEASED: assert property ((st == ST_TX) && (bitn > CHAR_ETU) |-> io_oe_n_o)
    else $error("line driven in guard");
  AST_NO_NACK_T1: assert property (t1 && (st == ST_RX) |=> st != ST_NACK)
    else $error("error signal under T=1");
  AST_SAMPLE_MID: assert property (rx_smp |->
    (ph == 9'(ETU_CYC / 2)) && (bitn >= 9'h001) && (bitn <= PAR_BIT))
    else $error("sample off centre");
  AST_FALSE_START: assert property ((st == ST_RX) && (bitn == 9'h000) && (ph == PH_MID) && io_s2 |=> st == ST_IDLE)
    else $error("glitch accepted as start");
  AST_ATR_LIMIT: assert property (ctrl.atr_mode |-> atr_idx <= ATR_MAX_CHARS)
    else $error("answer longer than allowed");

endmodule : ccl_link

`default_nettype wire

// [verification/ccl_term_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Terminal at the far end of the card I/O line
module ccl_term_model (
  // Clock
  input  wire logic clk_i,
  // Shared open-drain line
  input  wire logic line_i,
  output logic      oe_n_o
);
  logic       inv       = 1'b0;  // Inverse convention
  logic       nack_req  = 1'b0;  // Flag every received character
  logic       sending   = 1'b0;
  logic       nack_seen = 1'b0;
  logic       par_ok    = 1'b0;
  logic [7:0] rx_q[$];
  int         cyc       = 0;
  int         t_prev    = 0;
  int         last_gap  = 0;

  initial oe_n_o = 1'b1;

  // Cycle count for start spacing
  always @(posedge clk_i) cyc <= cyc + 1;

  // Send one character, then watch for an error signal
  task automatic send(input logic [7:0] b, input logic bad);
    logic [9:0] f;
    int         k;
    sending   = 1'b1;
    nack_seen = 1'b0;
    k = 0;
    while (line_i !== 1'b1 && k < 9999)
    begin
      @(posedge clk_i);
      k++;
    end
    f[0] = 1'b0;
    for (k = 0; k < 8; k++)
      f[k + 1] = (inv ? b[7 - k] : b[k]) ^ inv;
    f[9] = (^b) ^ bad ^ inv;
    for (k = 0; k < 10; k++)
    begin
      @(posedge clk_i);
      oe_n_o <= f[k];
      repeat (371) @(posedge clk_i);
    end
    @(posedge clk_i);
    oe_n_o <= 1'b1;
    repeat (372) @(posedge clk_i);
    nack_seen = (line_i === 1'b0);
    repeat (372) @(posedge clk_i);
    sending = 1'b0;
  endtask : send

  // Receive one character sampled at bit centres
  task automatic rx_char();
    logic [9:0] s;
    logic [7:0] d;
    int         k;
    if (t_prev != 0)
      last_gap = cyc - t_prev;
    t_prev = cyc;
    repeat (186) @(posedge clk_i);
    for (k = 0; k < 10; k++)
    begin
      s[k] = line_i ^ inv;
      if (k < 9)
        repeat (372) @(posedge clk_i);
    end
    for (k = 0; k < 8; k++)
      d[k] = inv ? s[8 - k] : s[k + 1];
    par_ok = ~^s[9:1];
    rx_q.push_back(d);
    if (nack_req || !par_ok)
    begin
      repeat (372) @(posedge clk_i);
      oe_n_o <= 1'b0;
      repeat (372) @(posedge clk_i);
      oe_n_o <= 1'b1;
    end
  endtask : rx_char

  // Wait for start bits from the card
  initial
  begin
    forever
    begin
      @(negedge line_i);
      if (!sending && line_i === 1'b0)
        rx_char();
    end
  end
endmodule : ccl_term_model

`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tb_top
  import ccl_pkg::*;
;
  // Bench signals
  logic        core_clk_i  = 1'b0;
  logic        sys_rst_i   = 1'b1;
  logic [3:0]  reg_addr    = 4'h0;
  logic [31:0] reg_wdata   = 32'h0;
  logic        reg_wr      = 1'b0;
  logic        reg_rd      = 1'b0;
  logic [31:0] reg_rdata;
  logic        io_o;
  logic        io_oe_n;
  logic        term_oe_n;
  wire         io_line;
  logic [31:0] st;
  logic [7:0]  atr [4]     = '{8'h3F, 8'h61, 8'h00, 8'h00};
  int          errors      = 0;
  int          comparisons = 0;

  // Clock and wired-and line with pull-up
  always #20 core_clk_i = ~core_clk_i;
  assign io_line = (io_oe_n | io_o) & term_oe_n;

  ccl_link #(
    .ATR_MAX_GAP_ETU(40),
    .ATR_TOTAL_ETU  (100)
  ) u_dut (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .reg_addr_i (reg_addr),
    .reg_wdata_i(reg_wdata),
    .reg_wr_i   (reg_wr),
    .reg_rd_i   (reg_rd),
    .reg_rdata_o(reg_rdata),
    .io_i       (io_line),
    .io_o       (io_o),
    .io_oe_n_o  (io_oe_n)
  );

  ccl_term_model u_term (
    .clk_i (core_clk_i),
    .line_i(io_line),
    .oe_n_o(term_oe_n)
  );

  // Register write, one strobe cycle
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk_i);
    reg_wr    <= 1'b0;
  endtask : wr

  // Register read, data taken one cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk_i);
    reg_rd   <= 1'b0;
    @(posedge core_clk_i);
    d = reg_rdata;
  endtask : rd

  // Set mode, clear flags and the terminal log
  task automatic prep(input logic [31:0] c, input logic iv);
    wr(REG_CTRL, c);
    wr(REG_STATUS, 32'hFF);
    u_term.inv = iv;
    u_term.rx_q.delete();
  endtask : prep

  // Poll until the transmitter is idle
  task automatic wait_idle();
    int n;
    n = 0;
    st = 32'h100;
    while (st[S_TX_BUSY] !== 1'b0 && n < 4000)
    begin
      rd(REG_STATUS, st);
      n++;
    end
    `CHK(st[S_TX_BUSY], 1'b0)
  endtask : wait_idle

  // Wait for the terminal to log n characters
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (u_term.rx_q.size() < n && k < 20000)
    begin
      @(posedge core_clk_i);
      k++;
    end
    `CHK(u_term.rx_q.size() >= n, 1'b1)
  endtask : wait_rx

  task automatic done(input string name);
    $display("test %s done", name);
  endtask : done

  task automatic close_out();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Watchdog
  initial
  begin
    repeat (96000) @(posedge core_clk_i);
    errors++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    close_out();
  end

  // Test sequence
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    rd(REG_CTRL, st);
    `CHK(st, 32'h0)
    rd(REG_STATUS, st);
    `CHK(st, 32'h0)
    rd(4'hF, st);
    `CHK(st, 32'h0)
    `CHK(io_oe_n, 1'b1)
    `CHK(io_o, 1'b0)
    done("reset");
    // Back-to-back sends with extra guard, third one refused
    prep(32'h0400, 1'b0);
    wr(REG_TXDATA, 32'hA5);
    wr(REG_TXDATA, 32'h5A);
    wr(REG_TXDATA, 32'hC3);
    wait_rx(2);
    wait_idle();
    `CHK(u_term.rx_q.size(), 2)
    `CHK(u_term.rx_q[0], 8'hA5)
    `CHK(u_term.rx_q[1], 8'h5A)
    `CHK(u_term.par_ok, 1'b1)
    `CHK(u_term.last_gap >= 16 * int'(ETU_CYC), 1'b1)
    rd(REG_STATUS, st);
    `CHK(st[F_TX_OVF], 1'b1)
    `CHK(st[F_TX_NACK], 1'b0)
    done("tx_direct");
    // Good character from the terminal
    prep(32'h0, 1'b0);
    u_term.send(8'h3C, 1'b0);
    rd(REG_STATUS, st);
    `CHK(st[1:0], 2'b01)
    rd(REG_RXDATA, st);
    `CHK(st[7:0], 8'h3C)
    rd(REG_STATUS, st);
    `CHK(st[F_RX_VALID], 1'b0)
    done("rx_direct");
    // Parity fault under T=0 and under T=1
    for (int p = 0; p < 2; p++)
    begin
      prep({30'h0, p[0], 1'b0}, 1'b0);
      u_term.send(8'h3C, 1'b1);
      `CHK(u_term.nack_seen, p == 0)
      rd(REG_STATUS, st);
      `CHK(st[F_RX_PERR], 1'b1)
    end
    done("rx_parity");
    // Inverse convention both ways
    prep(32'h1, 1'b1);
    wr(REG_TXDATA, 32'h3F);
    wait_rx(1);
    `CHK(u_term.rx_q[0], 8'h3F)
    wait_idle();
    u_term.send(8'h81, 1'b0);
    rd(REG_RXDATA, st);
    `CHK(st[7:0], 8'h81)
    done("inverse");
    // Terminal flags the card's character
    prep(32'h0, 1'b0);
    u_term.nack_req = 1'b1;
    wr(REG_TXDATA, 32'h55);
    wait_rx(1);
    repeat (3 * ETU_CYC) @(posedge core_clk_i);
    u_term.nack_req = 1'b0;
    rd(REG_STATUS, st);
    `CHK(st[F_TX_NACK], 1'b1)
    wait_idle();
    done("tx_nack");
    // Answer to reset with wrong TS, left unfinished
    prep(32'h4, 1'b0);
    foreach (atr[i])
    begin
      wr(REG_TXDATA, {24'h0, atr[i]});
      wait_idle();
    end
    repeat (60 * ETU_CYC) @(posedge core_clk_i);
    `CHK(u_term.rx_q.size(), 4)
    `CHK(u_term.last_gap >= 12 * int'(ETU_CYC), 1'b1)
    rd(REG_STATUS, st);
    `CHK(st[6:3], 4'b1011)
    done("atr");
    close_out();
  end
endmodule : tb_top

`default_nettype wire
